// ---- core/synth_cfg_pkg.sv ----
// Package: constants shared by the synthesizer configuration port
package synth_cfg_pkg;
  localparam int unsigned LOOP_W      = 9;
  localparam int unsigned ODIV_W      = 2;
  localparam int unsigned TSEL_W      = 3;
  localparam int unsigned SHIFT_W     = TSEL_W + ODIV_W + LOOP_W;
  localparam int unsigned REF_PREDIV  = 8;
  localparam int unsigned REF_CNT_W   = 3;
  localparam int unsigned LOOP_MIN    = 200;
  localparam int unsigned LOOP_MAX    = 400;
  // Field positions inside the shift register (last bit shifted sits at bit 0)
  localparam int unsigned LOOP_LSB    = 0;
  localparam int unsigned ODIV_LSB    = LOOP_W;
  localparam int unsigned TSEL_LSB    = LOOP_W + ODIV_W;
  // Output divider select codes
  localparam logic [1:0] ODIV_BY2     = 2'h0;
  localparam logic [1:0] ODIV_BY4     = 2'h1;
  localparam logic [1:0] ODIV_BY8     = 2'h2;
  localparam logic [1:0] ODIV_BY1     = 2'h3;
  // Observation select codes
  localparam logic [2:0] TSEL_SHIFT   = 3'h0;
  localparam logic [2:0] TSEL_HIGH    = 3'h1;
  localparam logic [2:0] TSEL_REF     = 3'h2;
  localparam logic [2:0] TSEL_LOOP    = 3'h3;
  localparam logic [2:0] TSEL_SYNTH   = 3'h4;
  localparam logic [2:0] TSEL_LOW     = 3'h5;
  localparam logic [2:0] TSEL_BYPASS  = 3'h6;
  localparam logic [2:0] TSEL_SYNTH4  = 3'h7;
  localparam logic [2:0] TSEL_RESET   = 3'h0;
  localparam logic [8:0] LOOP_RESET   = 9'h0c8;
  localparam logic [1:0] ODIV_RESET   = 2'h0;
endpackage

// ---- core/sync2.sv ----
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;
endmodule

// ---- core/mod_counter.sv ----
// Programmable modulus counter with one-cycle terminal pulse and square wave
`timescale 1ns/1ps
module mod_counter #(
  parameter int unsigned WIDTH = 9
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // Count control
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] modulus,
  // Outputs
  output logic                  wrap,
  output logic                  square
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             sq;
  } cnt_state_t;

  cnt_state_t st_r;
  cnt_state_t st_nxt;
  logic       at_end;

  // A modulus of zero or one wraps on every step
  assign at_end = (st_r.cnt + WIDTH'(1) >= modulus);

  always_comb begin
    st_nxt = st_r;
    if (clk_en && step) begin
      if (at_end) begin
        st_nxt.cnt = '0;
        st_nxt.sq  = ~st_r.sq;
      end else begin
        st_nxt.cnt = st_r.cnt + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wrap   = step && at_end;
  assign square = st_r.sq;
endmodule

// ---- core/synth_divider_config_port.sv ----
// Configuration port of the frequency synthesizer: parallel and serial loading, test mux
`timescale 1ns/1ps
module synth_divider_config_port #(
  parameter int unsigned LOOP_W = synth_cfg_pkg::LOOP_W,
  parameter int unsigned ODIV_W = synth_cfg_pkg::ODIV_W
) (
  // Clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Parallel configuration pins
  input  wire logic              parallel_load_strobe_low,
  input  wire logic [LOOP_W-1:0] loop_div_in,
  input  wire logic [ODIV_W-1:0] out_div_in,
  // Serial configuration pins
  input  wire logic              shift_clock_input,
  input  wire logic              shift_data_in,
  input  wire logic              serial_load_strobe,
  // Oscillator-side ticks (VCO and reference model, same clock domain)
  input  wire logic              vco_tick,
  input  wire logic              ref_tick,
  // Outputs
  output logic                   synth_output,
  output logic                   synth_output_n,
  output logic                   test_out,
  output logic [LOOP_W-1:0]      loop_div_active,
  output logic [ODIV_W-1:0]      out_div_active,
  output logic [2:0]             test_sel_active,
  output logic                   loop_in_range
);
  localparam int unsigned SW = synth_cfg_pkg::SHIFT_W;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [LOOP_W+ODIV_W+3:0] pins_s;

  sync2 #(
    .WIDTH(LOOP_W + ODIV_W + 4)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in ({parallel_load_strobe_low, loop_div_in, out_div_in,
                shift_clock_input, shift_data_in, serial_load_strobe}),
    .sync_out (pins_s)
  );

  logic              pload_s;
  logic [LOOP_W-1:0] loop_s;
  logic [ODIV_W-1:0] odiv_s;
  logic              sclk_s;
  logic              sdata_s;
  logic              sload_s;

  assign {pload_s, loop_s, odiv_s, sclk_s, sdata_s, sload_s} = pins_s;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic              pload_d;
    logic              sclk_d;
    logic              sload_d;
    logic [SW-1:0]     shreg;
    logic [LOOP_W-1:0] loop_div;
    logic [ODIV_W-1:0] out_div;
    logic [2:0]        test_sel;
    logic [2:0]        ref_cnt;
    logic              ref_sq;
    logic [2:0]        synth_q;
    logic              test_q;
  } cfg_state_t;

  cfg_state_t st_r;
  cfg_state_t st_nxt;

  logic sclk_rise;
  logic sload_fall;
  logic bypass;
  logic count_step;
  logic loop_wrap;
  logic loop_sq;
  logic odiv_wrap;
  logic odiv_sq;
  logic odiv_tick;
  logic test_nxt;

  assign sclk_rise  = sclk_s & ~st_r.sclk_d;
  assign sload_fall = ~sload_s & st_r.sload_d;
  assign bypass     = (st_r.test_sel == synth_cfg_pkg::TSEL_BYPASS);
  // In bypass both dividers step on the shift clock rather than the VCO
  assign count_step = bypass ? sclk_rise : vco_tick;

  // Output divider ratio from select code
  function automatic logic [3:0] odiv_ratio(input logic [1:0] sel);
    unique case (sel)
      synth_cfg_pkg::ODIV_BY2: odiv_ratio = 4'h2;
      synth_cfg_pkg::ODIV_BY4: odiv_ratio = 4'h4;
      synth_cfg_pkg::ODIV_BY8: odiv_ratio = 4'h8;
      synth_cfg_pkg::ODIV_BY1: odiv_ratio = 4'h1;
    endcase
  endfunction

  // Loop counter: the PLL feedback divider; in bypass its narrow pulse is not 50% duty
  mod_counter #(
    .WIDTH(LOOP_W)
  ) u_loop (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .step     (count_step),
    .modulus  (st_r.loop_div),
    .wrap     (loop_wrap),
    .square   (loop_sq)
  );

  // Output divider counts half periods so the output toggles at the ratio
  mod_counter #(
    .WIDTH(4)
  ) u_odiv (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .step     (count_step),
    .modulus  (odiv_ratio(st_r.out_div)),
    .wrap     (odiv_wrap),
    .square   (odiv_sq)
  );

  assign odiv_tick = odiv_wrap;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    test_nxt = 1'b0;
    st_nxt.pload_d = pload_s;
    st_nxt.sclk_d  = sclk_s;
    st_nxt.sload_d = sload_s;

    if (!pload_s) begin
      // Transparent parallel latches; the last value before the rise is kept
      st_nxt.loop_div = loop_s;
      st_nxt.out_div  = odiv_s;
      st_nxt.test_sel = synth_cfg_pkg::TSEL_RESET;
    end else begin
      if (sclk_rise) begin
        st_nxt.shreg = {st_r.shreg[SW-2:0], sdata_s};
      end
      // Serial latches follow the shift register while the strobe is high,
      // so the value present at its falling edge is what stays
      if (sload_s || sload_fall) begin
        st_nxt.loop_div = st_r.shreg[synth_cfg_pkg::LOOP_LSB +: LOOP_W];
        st_nxt.out_div  = st_r.shreg[synth_cfg_pkg::ODIV_LSB +: ODIV_W];
        st_nxt.test_sel = st_r.shreg[synth_cfg_pkg::TSEL_LSB +: 3];
      end
    end

    // Reference divided by 8
    if (ref_tick) begin
      st_nxt.ref_cnt = st_r.ref_cnt + 3'h1;
      if (st_r.ref_cnt == 3'(synth_cfg_pkg::REF_PREDIV / 2 - 1)) begin
        st_nxt.ref_cnt = '0;
        st_nxt.ref_sq  = ~st_r.ref_sq;
      end
    end

    // Synthesized output toggles per half period; bit 2 is output divided by four
    if (odiv_tick) begin
      st_nxt.synth_q = st_r.synth_q + 3'h1;
    end

    unique case (st_r.test_sel)
      synth_cfg_pkg::TSEL_SHIFT:  test_nxt = st_r.shreg[SW-1];
      synth_cfg_pkg::TSEL_HIGH:   test_nxt = 1'b1;
      synth_cfg_pkg::TSEL_REF:    test_nxt = st_r.ref_sq;
      synth_cfg_pkg::TSEL_LOOP:   test_nxt = loop_sq;
      synth_cfg_pkg::TSEL_SYNTH:  test_nxt = odiv_sq;
      synth_cfg_pkg::TSEL_LOW:    test_nxt = 1'b0;
      synth_cfg_pkg::TSEL_BYPASS: test_nxt = loop_wrap;
      synth_cfg_pkg::TSEL_SYNTH4: test_nxt = st_r.synth_q[2];
    endcase
    // Observation latch held in reset: first test bit of the shifted data shows
    if (!pload_s) begin
      test_nxt = st_r.shreg[SW-1];
    end
    st_nxt.test_q = test_nxt;

    if (!clk_en) begin
      st_nxt = st_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r          <= '0;
      st_r.loop_div <= synth_cfg_pkg::LOOP_RESET;
      st_r.out_div  <= synth_cfg_pkg::ODIV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign synth_output     = odiv_sq;
  assign synth_output_n   = ~odiv_sq;
  assign test_out         = st_r.test_q;
  assign loop_div_active  = st_r.loop_div;
  assign out_div_active   = st_r.out_div;
  assign test_sel_active  = st_r.test_sel;
  // Flag only; the controller keeps the value legal
  assign loop_in_range    = (st_r.loop_div >= LOOP_W'(synth_cfg_pkg::LOOP_MIN)) &&
                            (st_r.loop_div <= LOOP_W'(synth_cfg_pkg::LOOP_MAX));
endmodule

// ---- verif/synth_cfg_sva.sv ----
// Checker of the synthesizer configuration port
`timescale 1ns/1ps
module synth_cfg_sva #(
  parameter int unsigned LOOP_W = 9,
  parameter int unsigned ODIV_W = 2
) (
  // Watched ports
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              clk_en,
  input wire logic              parallel_load_strobe_low,
  input wire logic [LOOP_W-1:0] loop_div_in,
  input wire logic [ODIV_W-1:0] out_div_in,
  input wire logic              serial_load_strobe,
  input wire logic              synth_output,
  input wire logic              synth_output_n,
  input wire logic              test_out,
  input wire logic [LOOP_W-1:0] loop_div_active,
  input wire logic [ODIV_W-1:0] out_div_active,
  input wire logic [2:0]        test_sel_active,
  input wire logic              loop_in_range
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_PAR_LOOP: assert property (
    (clk_en && !parallel_load_strobe_low && $stable(loop_div_in))[*5]
    |-> loop_div_active == loop_div_in) else $error("loop value not following pins");
  AST_PAR_ODIV: assert property (
    (clk_en && !parallel_load_strobe_low && $stable(out_div_in))[*5]
    |-> out_div_active == out_div_in) else $error("output ratio not following pins");
  AST_TSEL_ZERO: assert property (
    (clk_en && !parallel_load_strobe_low)[*4] |-> test_sel_active == 3'h0)
    else $error("test select not cleared");
  // Both strobes idle: nothing may move the dividers
  AST_FREEZE: assert property (
    (parallel_load_strobe_low && !serial_load_strobe)[*5]
    |-> $stable(loop_div_active) && $stable(out_div_active)) else $error("dividers moved");
  AST_RANGE: assert property (
    loop_in_range == (loop_div_active >= 9'h0c8 && loop_div_active <= 9'h190))
    else $error("range flag wrong");
  AST_COMP: assert property (
    synth_output_n != synth_output) else $error("output pair not complementary");
  AST_TEST_HIGH: assert property (
    (clk_en && test_sel_active == 3'h1)[*2] |-> test_out) else $error("test not high");
  AST_TEST_LOW: assert property (
    (clk_en && test_sel_active == 3'h5)[*2] |-> !test_out) else $error("test not low");
endmodule

bind synth_divider_config_port synth_cfg_sva #(.LOOP_W(LOOP_W), .ODIV_W(ODIV_W)) i_sva (
  .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .parallel_load_strobe_low(parallel_load_strobe_low), .loop_div_in(loop_div_in),
  .out_div_in(out_div_in), .serial_load_strobe(serial_load_strobe),
  .synth_output(synth_output), .synth_output_n(synth_output_n), .test_out(test_out),
  .loop_div_active(loop_div_active), .out_div_active(out_div_active),
  .test_sel_active(test_sel_active), .loop_in_range(loop_in_range)
);

// ---- verif/cfg_host_model.sv ----
// Board controller model driving the parallel pins and the serial port
`timescale 1ns/1ps
module cfg_host_model (
  // Clock
  input  wire logic core_clk,
  // Configuration pins
  output logic       parallel_load_strobe_low,
  output logic [8:0] loop_div_in,
  output logic [1:0] out_div_in,
  output logic       shift_clock_input,
  output logic       shift_data_in,
  output logic       serial_load_strobe
);
  // ----------------------------------------
  // Pin sequences
  // ----------------------------------------
  // Power-up: parallel strobe low, serial pins at their pull-down level
  initial begin
    parallel_load_strobe_low = 1'b0;
    loop_div_in = 9'h0c8;
    out_div_in = 2'h0;
    shift_clock_input = 1'b0;
    shift_data_in = 1'b0;
    serial_load_strobe = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic par_open(input logic [8:0] m, input logic [1:0] n);
    wait_n(1);
    parallel_load_strobe_low = 1'b0;
    loop_div_in = m;
    out_div_in = n;
    wait_n(6);
  endtask
  // Values stay put past the rising edge so the capture is clean
  task automatic par_close();
    parallel_load_strobe_low = 1'b1;
    wait_n(6);
  endtask
  // Shift clock stands still low between frames; each half lasts 3 cycles
  task automatic ser_load(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      shift_data_in = w[i];
      wait_n(3);
      shift_clock_input = 1'b1;
      wait_n(3);
      shift_clock_input = 1'b0;
    end
    shift_data_in = 1'b0;
    serial_load_strobe = 1'b1;
    wait_n(4);
    serial_load_strobe = 1'b0;
    wait_n(6);
  endtask
endmodule

// ---- verif/synth_divider_config_port_tb.sv ----
// Testbench of the synthesizer configuration port
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module synth_divider_config_port_tb;
  logic       core_clk, reset, clk_en;
  logic       vco_tick = 1'b0;
  logic       ref_tick = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  realtime    t0;
  logic       plsl, sclk, sdat, sload;
  logic [8:0] loop_div_in, loop_div_active;
  logic [1:0] out_div_in, out_div_active;
  logic [2:0] test_sel_active;
  logic       synth_output, synth_output_n, test_out, loop_in_range;
  int         fail_count = 0;
  int         total_checks = 0;
  logic [8:0] pm [4] = '{9'h0c7, 9'h106, 9'h190, 9'h191};
  logic       pr [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [2:0] sc [2] = '{3'h1, 3'h5};
  synth_divider_config_port i_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .parallel_load_strobe_low(plsl), .loop_div_in(loop_div_in), .out_div_in(out_div_in),
    .shift_clock_input(sclk), .shift_data_in(sdat), .serial_load_strobe(sload),
    .vco_tick(vco_tick), .ref_tick(ref_tick), .synth_output(synth_output),
    .synth_output_n(synth_output_n), .test_out(test_out), .loop_div_active(loop_div_active),
    .out_div_active(out_div_active), .test_sel_active(test_sel_active),
    .loop_in_range(loop_in_range));
  cfg_host_model i_host (
    .core_clk(core_clk), .parallel_load_strobe_low(plsl), .loop_div_in(loop_div_in),
    .out_div_in(out_div_in), .shift_clock_input(sclk), .shift_data_in(sdat),
    .serial_load_strobe(sload));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Stand-in oscillator ticks
  always @(negedge core_clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    vco_tick <= tick_cnt[0];
    ref_tick <= (tick_cnt == 3'h0);
  end
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHK(loop_div_active, 9'h0c8) // reset state
    `CHK(synth_output_n, 1'b1) // reset state
    reset = 1'b0;
    // Every ratio code, range boundaries on both sides
    for (int i = 0; i < 4; i++) begin
      i_host.par_open(pm[i], 2'(i));
      `CHK(loop_div_active, pm[i])
      `CHK(test_sel_active, 3'h0)
      i_host.par_close();
      i_host.loop_div_in = ~pm[i];
      i_host.wait_n(6);
      `CHK(loop_div_active, pm[i])
      `CHK(out_div_active, 2'(i))
      `CHK(loop_in_range, pr[i])
    end
    // Ratio 1 with a tick every second cycle: output half period is two cycles
    @(synth_output);
    t0 = $realtime;
    @(synth_output);
    `CHK(int'(($realtime - t0) / 100.0), 2)
    i_host.wait_n(1);
    // Enable low freezes the synchronisers, so open latches must not follow
    clk_en = 1'b0;
    i_host.par_open(9'h0d0, 2'h1);
    `CHK(loop_div_active, pm[3])
    clk_en = 1'b1;
    i_host.wait_n(6);
    `CHK(loop_div_active, 9'h0d0)
    i_host.par_close();
    $display("test parallel done");
    // Loop value stepped by one between frames
    for (int i = 0; i < 2; i++) begin
      i_host.ser_load({sc[i], 2'(i + 1), 9'h106 + 9'(i)});
      `CHK(loop_div_active, 9'h106 + 9'(i))
      `CHK(out_div_active, 2'(i + 1))
      `CHK(test_sel_active, sc[i])
      `CHK(test_out, ~sc[i][2])
    end
    $display("test serial done");
    // A frame sent while the parallel latches are open must be ignored
    i_host.par_open(9'h150, 2'h3);
    i_host.ser_load({3'h1, 2'h0, 9'h0c8});
    `CHK(loop_div_active, 9'h150)
    `CHK(test_sel_active, 3'h0)
    i_host.par_close();
    `CHK(test_sel_active, 3'h0)
    $display("test refusal done");
    report_and_stop();
  end
endmodule
